/* rtl/scpm_map.svh */
// register offsets, field positions, reset values and timing counts for the cam monitor
// assumes inclusion by bare name from the design files
`ifndef SCPM_MAP_SVH
`define SCPM_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SCPM_OFS_ENABLE 8'h00
`define SCPM_OFS_CAM_TOLERANCE 8'h04
`define SCPM_OFS_POSITION_TOLERANCE 8'h08
`define SCPM_OFS_MOD_RANGE 8'h0C
`define SCPM_OFS_STATUS 8'h10
`define SCPM_OFS_IRQ_STATUS 8'h14
`define SCPM_OFS_IRQ_ENABLE 8'h18
`define SCPM_OFS_IRQ_CLEAR 8'h1C
`define SCPM_OFS_CONTROL 8'h20
`define SCPM_OFS_CAM_PLUS 8'h40
`define SCPM_OFS_CAM_MINUS 8'h50
`define SCPM_OFS_OUT_PLUS 8'h60
`define SCPM_OFS_OUT_MINUS 8'h70

// ----------------------------------------
// field positions
// ----------------------------------------
`define SCPM_BIT_SYNC 7
`define SCPM_BIT_ROTARY 0
`define SCPM_BIT_START 1
`define SCPM_BIT_REFERENCED 2
`define SCPM_CAM_EN_LSB 8
`define SCPM_CAM_EN_MSB 15
`define SCPM_IRQ_CFG_ERR 0
`define SCPM_IRQ_CAM_CHG 1

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SCPM_RST_ENABLE 32'h0000_0000
`define SCPM_RST_MOD_RANGE 32'h0005_7E40
`define SCPM_CYCLE_NS 32'd100000
`define SCPM_CLK_NS 32'd5
`define SCPM_CYCLE_COUNT (`SCPM_CYCLE_NS / `SCPM_CLK_NS)

`endif

/* rtl/scpm_pkg.sv */
// types shared by the cam monitor files
// assumes nothing of its surroundings
package scpm_pkg;
  typedef enum logic [1:0] {
    scpm_st_idle,
    scpm_st_check,
    scpm_st_run
  } scpm_state_t;
  typedef logic signed [31:0] scpm_pos_t;
endpackage

/* rtl/scpm_cfg_mem.sv */
// small register-output memory holding per-cam words
// assumes one writer and one reader on the system clock
`timescale 1ns/1ps
module scpm_cfg_mem #(
  parameter int depth = 16,
  parameter int width = 32
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [$clog2(depth)-1:0] wr_addr,
  input wire logic [width-1:0] wr_data,
  input wire logic [$clog2(depth)-1:0] rd_addr,
  output logic [width-1:0] rd_data
);
  logic [width-1:0] mem [depth];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

/* rtl/scpm_top.sv */
// safe cam position monitor for one axis with wishbone register access
// assumes synchronous inputs, a 200 MHz clock and a wishbone classic master
// Overview of operation
// - four cam pairs per axis, each plus and minus cam with its own output.
// - eight enable bits (positions 8 to 15) turn on individual cams; disabled cams stay low.
// - plus and minus cam positions come from two separate arrays indexed by cam number.
// - cam outputs run from reset onward and a separate output shows safe referencing.
// - channel disagreement within the cam tolerance band is not an error.
// - with sync enabled (bit 7) own results are ANDed with the other channel's.
// - with sync enabled outputs switch with direction hysteresis of cam tolerance width.
// - rotary axes wrap the position into the configured modulo range.
// - without sync each cam must be at least low+position_tolerance and below high-position_tolerance.
// - with sync each cam must be at least low+position_tolerance and below high-position_tolerance-cam_tolerance.
// - on rotary axes the enabled cams are checked during run-up and an alarm is raised afterward.
// - plus and minus outputs are routed to terminals by two assignment arrays.
`timescale 1ns/1ps
`include "scpm_map.svh"
module scpm_top #(
  parameter int num_pairs = 4,
  parameter int num_terms = 16,
  parameter int cycle_count = `SCPM_CYCLE_COUNT
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [31:0] safe_position,
  input wire logic [num_pairs-1:0] other_plus_cam,
  input wire logic [num_pairs-1:0] other_minus_cam,
  output logic [num_pairs-1:0] plus_cam,
  output logic [num_pairs-1:0] minus_cam,
  output logic [num_terms-1:0] safe_output_signal,
  output logic axis_referenced,
  output logic config_alarm,
  output logic irq
);
  localparam int aw = $clog2(num_terms);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // modulo limits checked against one cam position
  function automatic logic cam_pos_ok(input scpm_pkg::scpm_pos_t pos,
                                      input scpm_pkg::scpm_pos_t ptol,
                                      input scpm_pkg::scpm_pos_t ctol,
                                      input scpm_pkg::scpm_pos_t range,
                                      input logic sync);
    scpm_pkg::scpm_pos_t hi;
    hi = sync ? range - ptol - ctol : range - ptol;
    return (pos >= ptol) && (pos < hi);
  endfunction

  // shadow word k holds plus cam k, or minus cam k-num_pairs; pick its own enable bit
  function automatic logic word_enabled(input logic [3:0] k, input logic [7:0] en);
    if (k < 4'(num_pairs)) begin
      return en[3'(2 * k + 4'h1)];
    end
    return en[3'(2 * (k - 4'(num_pairs)))];
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] func_enable;
  logic [31:0] cam_tolerance;
  logic [31:0] position_tolerance;
  logic [31:0] mod_range;
  logic [31:0] control;
  logic [1:0] irq_status;
  logic [1:0] irq_enable;
  logic [31:0] cam_plus_pos [num_pairs];
  logic [31:0] cam_minus_pos [num_pairs];
  logic [7:0] out_plus_map [num_pairs];
  logic [7:0] out_minus_map [num_pairs];
  logic req;
  logic wr;
  logic sync_en;
  logic rotary;
  logic [7:0] cam_en;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign sync_en = func_enable[`SCPM_BIT_SYNC];
  assign cam_en = func_enable[`SCPM_CAM_EN_MSB:`SCPM_CAM_EN_LSB];
  assign rotary = control[`SCPM_BIT_ROTARY];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      func_enable <= `SCPM_RST_ENABLE;
      cam_tolerance <= 32'h0000_0000;
      position_tolerance <= 32'h0000_0000;
      mod_range <= `SCPM_RST_MOD_RANGE;
      control <= 32'h0000_0000;
      irq_enable <= 2'h0;
    end else if (wr) begin
      unique case (wb_adr_i)
        `SCPM_OFS_ENABLE: func_enable <= merge_bytes(func_enable, wb_dat_i, wb_sel_i);
        `SCPM_OFS_CAM_TOLERANCE: cam_tolerance <= merge_bytes(cam_tolerance, wb_dat_i, wb_sel_i);
        `SCPM_OFS_POSITION_TOLERANCE: position_tolerance <= merge_bytes(position_tolerance, wb_dat_i, wb_sel_i);
        `SCPM_OFS_MOD_RANGE: mod_range <= merge_bytes(mod_range, wb_dat_i, wb_sel_i);
        `SCPM_OFS_CONTROL: control <= merge_bytes(control, wb_dat_i, wb_sel_i);
        `SCPM_OFS_IRQ_ENABLE: irq_enable <= wb_dat_i[1:0];
        default: ;
      endcase
    end
  end

  // per-cam arrays: 16 byte windows, word index in bits 3:2
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      for (int i = 0; i < num_pairs; i++) begin
        cam_plus_pos[i] <= 32'h0000_0000;
        cam_minus_pos[i] <= 32'h0000_0000;
        out_plus_map[i] <= 8'(2 * i);
        out_minus_map[i] <= 8'(2 * i + 1);
      end
    end else if (wr) begin
      for (int i = 0; i < num_pairs; i++) begin
        if (wb_adr_i == `SCPM_OFS_CAM_PLUS + 8'(4 * i)) begin
          cam_plus_pos[i] <= merge_bytes(cam_plus_pos[i], wb_dat_i, wb_sel_i);
        end
        if (wb_adr_i == `SCPM_OFS_CAM_MINUS + 8'(4 * i)) begin
          cam_minus_pos[i] <= merge_bytes(cam_minus_pos[i], wb_dat_i, wb_sel_i);
        end
        if (wb_adr_i == `SCPM_OFS_OUT_PLUS + 8'(4 * i)) begin
          out_plus_map[i] <= wb_dat_i[7:0];
        end
        if (wb_adr_i == `SCPM_OFS_OUT_MINUS + 8'(4 * i)) begin
          out_minus_map[i] <= wb_dat_i[7:0];
        end
      end
    end
  end

  // ----------------------------------------
  // run-up configuration check
  // ----------------------------------------
  // a single mem holds a shadow of positions so the check walks one word per cycle,
  // trading run-up time for a single comparator
  scpm_pkg::scpm_state_t state;
  logic [3:0] chk_idx;
  logic [31:0] chk_word;
  logic chk_fail;
  logic [3:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic mem_we;

  always_comb begin
    mem_we = 1'b0;
    mem_waddr = 4'h0;
    mem_wdata = wb_dat_i;
    for (int i = 0; i < num_pairs; i++) begin
      if (wr && wb_adr_i == `SCPM_OFS_CAM_PLUS + 8'(4 * i)) begin
        mem_we = 1'b1;
        mem_waddr = 4'(i);
        mem_wdata = merge_bytes(cam_plus_pos[i], wb_dat_i, wb_sel_i);
      end
      if (wr && wb_adr_i == `SCPM_OFS_CAM_MINUS + 8'(4 * i)) begin
        mem_we = 1'b1;
        mem_waddr = 4'(i + num_pairs);
        mem_wdata = merge_bytes(cam_minus_pos[i], wb_dat_i, wb_sel_i);
      end
    end
  end

  scpm_cfg_mem #(.depth(16), .width(32)) u_mem (
    .clock(clock),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(chk_idx),
    .rd_data(chk_word)
  );

  logic start_req;
  assign start_req = wr && wb_adr_i == `SCPM_OFS_CONTROL && wb_sel_i[0]
                     && wb_dat_i[`SCPM_BIT_START];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= scpm_pkg::scpm_st_idle;
      chk_idx <= 4'h0;
      chk_fail <= 1'b0;
      config_alarm <= 1'b0;
    end else begin
      unique case (state)
        scpm_pkg::scpm_st_idle: begin
          if (start_req) begin
            state <= scpm_pkg::scpm_st_check;
            chk_idx <= 4'h0;
            chk_fail <= 1'b0;
            config_alarm <= 1'b0;
          end
        end
        scpm_pkg::scpm_st_check: begin
          chk_idx <= chk_idx + 4'h1;
          // read data lags index by one cycle
          if (chk_idx != 4'h0) begin
            if (rotary && word_enabled(chk_idx - 4'h1, cam_en)
                && !cam_pos_ok(chk_word, position_tolerance, cam_tolerance, mod_range, sync_en)) begin
              chk_fail <= 1'b1;
            end
          end
          if (chk_idx == 4'(2 * num_pairs)) begin
            state <= scpm_pkg::scpm_st_run;
          end
        end
        scpm_pkg::scpm_st_run: begin
          config_alarm <= chk_fail;
          if (start_req) begin
            state <= scpm_pkg::scpm_st_check;
            chk_idx <= 4'h0;
            chk_fail <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // monitoring cycle and cam evaluation
  // ----------------------------------------
  logic [31:0] cyc_cnt;
  logic tick;
  scpm_pkg::scpm_pos_t pos_mod;
  logic [num_pairs-1:0] raw_plus;
  logic [num_pairs-1:0] raw_minus;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cyc_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      tick <= (cyc_cnt == 32'(cycle_count - 1));
      cyc_cnt <= (cyc_cnt == 32'(cycle_count - 1)) ? 32'h0000_0000 : cyc_cnt + 32'h1;
    end
  end

  // wrap for endless rotary axes; one range step covers per-cycle motion
  always_comb begin
    pos_mod = safe_position;
    if (rotary) begin
      if (pos_mod >= scpm_pkg::scpm_pos_t'(mod_range)) begin
        pos_mod = pos_mod - mod_range;
      end else if (pos_mod < 0) begin
        pos_mod = pos_mod + mod_range;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < num_pairs; i++) begin
      raw_plus[i] = pos_mod > scpm_pkg::scpm_pos_t'(cam_plus_pos[i]);
      raw_minus[i] = pos_mod < scpm_pkg::scpm_pos_t'(cam_minus_pos[i]);
      // hysteresis: leave a set state only after cam_tolerance beyond the edge
      if (sync_en && plus_cam[i]) begin
        raw_plus[i] = pos_mod > scpm_pkg::scpm_pos_t'(cam_plus_pos[i] - cam_tolerance);
      end
      if (sync_en && minus_cam[i]) begin
        raw_minus[i] = pos_mod < scpm_pkg::scpm_pos_t'(cam_minus_pos[i] + cam_tolerance);
      end
    end
  end

  logic [num_pairs-1:0] en_plus;
  logic [num_pairs-1:0] en_minus;
  logic [num_pairs-1:0] next_plus;
  logic [num_pairs-1:0] next_minus;
  always_comb begin
    for (int i = 0; i < num_pairs; i++) begin
      en_plus[i] = cam_en[2 * i + 1];
      en_minus[i] = cam_en[2 * i];
    end
    // sync ANDs with the other channel; without it, disagreement is tolerated
    next_plus = raw_plus & en_plus & (sync_en ? other_plus_cam : '1);
    next_minus = raw_minus & en_minus & (sync_en ? other_minus_cam : '1);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      plus_cam <= '0;
      minus_cam <= '0;
    end else if (tick) begin
      plus_cam <= next_plus;
      minus_cam <= next_minus;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      safe_output_signal <= '0;
    end else begin
      for (int t = 0; t < num_terms; t++) begin
        safe_output_signal[t] <= 1'b0;
        for (int i = 0; i < num_pairs; i++) begin
          if (out_plus_map[i] == 8'(t) && plus_cam[i]) begin
            safe_output_signal[t] <= 1'b1;
          end
          if (out_minus_map[i] == 8'(t) && minus_cam[i]) begin
            safe_output_signal[t] <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      axis_referenced <= 1'b0;
    end else begin
      axis_referenced <= control[`SCPM_BIT_REFERENCED];
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic cam_change;
  logic alarm_rise;
  logic [1:0] irq_clr;
  assign cam_change = tick && ((next_plus != plus_cam) || (next_minus != minus_cam));
  assign alarm_rise = state == scpm_pkg::scpm_st_run && chk_fail && !config_alarm;
  assign irq_clr = (wr && wb_adr_i == `SCPM_OFS_IRQ_CLEAR) ? wb_dat_i[1:0] : 2'h0;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_status <= 2'h0;
      irq <= 1'b0;
    end else begin
      // set wins over clear
      irq_status[`SCPM_IRQ_CFG_ERR] <= alarm_rise
        || (irq_status[`SCPM_IRQ_CFG_ERR] && !irq_clr[`SCPM_IRQ_CFG_ERR]);
      irq_status[`SCPM_IRQ_CAM_CHG] <= cam_change
        || (irq_status[`SCPM_IRQ_CAM_CHG] && !irq_clr[`SCPM_IRQ_CAM_CHG]);
      irq <= |(irq_status & irq_enable);
    end
  end

  // ----------------------------------------
  // bus read and ack
  // ----------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      `SCPM_OFS_ENABLE: rd_mux = func_enable;
      `SCPM_OFS_CAM_TOLERANCE: rd_mux = cam_tolerance;
      `SCPM_OFS_POSITION_TOLERANCE: rd_mux = position_tolerance;
      `SCPM_OFS_MOD_RANGE: rd_mux = mod_range;
      `SCPM_OFS_CONTROL: rd_mux = control;
      `SCPM_OFS_STATUS: rd_mux = {22'h0, config_alarm, axis_referenced,
                                  minus_cam, plus_cam};
      `SCPM_OFS_IRQ_STATUS: rd_mux = {30'h0, irq_status};
      `SCPM_OFS_IRQ_ENABLE: rd_mux = {30'h0, irq_enable};
      default: ;
    endcase
    for (int i = 0; i < num_pairs; i++) begin
      if (wb_adr_i == `SCPM_OFS_CAM_PLUS + 8'(4 * i)) rd_mux = cam_plus_pos[i];
      if (wb_adr_i == `SCPM_OFS_CAM_MINUS + 8'(4 * i)) rd_mux = cam_minus_pos[i];
      if (wb_adr_i == `SCPM_OFS_OUT_PLUS + 8'(4 * i)) rd_mux = {24'h0, out_plus_map[i]};
      if (wb_adr_i == `SCPM_OFS_OUT_MINUS + 8'(4 * i)) rd_mux = {24'h0, out_minus_map[i]};
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req && !wb_we_i) ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_disabled_low: assert property (@(posedge clock) disable iff (!reset_n)
    !cam_en[1] |-> ##1 !$rose(plus_cam[0])) else $error("disabled cam rose");
  chk_sync_and: assert property (@(posedge clock) disable iff (!reset_n)
    (tick && sync_en && !other_plus_cam[0]) |=> !plus_cam[0])
    else $error("sync and not applied");
  chk_plus_above: assert property (@(posedge clock) disable iff (!reset_n)
    (tick && !sync_en && cam_en[1] && pos_mod > scpm_pkg::scpm_pos_t'(cam_plus_pos[0]))
    |=> plus_cam[0]) else $error("plus cam missing");
  chk_minus_below: assert property (@(posedge clock) disable iff (!reset_n)
    (tick && !sync_en && cam_en[0] && pos_mod >= scpm_pkg::scpm_pos_t'(cam_minus_pos[0]))
    |=> !minus_cam[0]) else $error("minus cam wrong");
  chk_hold_tick: assert property (@(posedge clock) disable iff (!reset_n)
    !tick |=> $stable(plus_cam)) else $error("cam moved off tick");
  chk_wrap_range: assert property (@(posedge clock) disable iff (!reset_n)
    (rotary && safe_position < mod_range && !safe_position[31]) |-> pos_mod == safe_position)
    else $error("wrap altered in-range position");
  chk_alarm_follow: assert property (@(posedge clock) disable iff (!reset_n)
    (state == scpm_pkg::scpm_st_run && chk_fail) |=> config_alarm)
    else $error("alarm not raised");
  chk_route_plus: assert property (@(posedge clock) disable iff (!reset_n)
    (plus_cam[0] && out_plus_map[0] < 8'(num_terms))
    |=> safe_output_signal[$past(out_plus_map[0][aw-1:0])])
    else $error("plus route lost");
  chk_ref_follow: assert property (@(posedge clock) disable iff (!reset_n)
    control[`SCPM_BIT_REFERENCED] |=> axis_referenced) else $error("referenced lost");
endmodule

/* dv/scpm_other_channel.sv */
// model of the redundant monitoring channel and of the terminal consumer
// assumes the bench chooses the other channel's cam results through pattern
`timescale 1ns/1ps
module scpm_other_channel (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] pattern,
  input wire logic [15:0] safe_output_signal,
  input wire logic axis_referenced,
  output logic [3:0] other_plus_cam,
  output logic [3:0] other_minus_cam,
  output logic [15:0] trusted_terms
);
  // ----------------------------------------
  // redundant channel results
  // ----------------------------------------
  // one clock late, as a slower channel would be
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      other_plus_cam <= 4'h0;
      other_minus_cam <= 4'h0;
    end else begin
      other_plus_cam <= pattern[3:0];
      other_minus_cam <= pattern[7:4];
    end
  end

  // ----------------------------------------
  // consumer view of the terminals
  // ----------------------------------------
  // cams are not trusted before referencing
  always_ff @(posedge clock) begin
    trusted_terms <= axis_referenced ? safe_output_signal : 16'h0000;
  end
endmodule

/* dv/scpm_top_tb.sv */
// self-checking bench for the safe cam position monitor
// assumes the other channel model and the design files under rtl/
`timescale 1ns/1ps
`include "scpm_map.svh"
module scpm_top_tb;
  localparam int cc = 8;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] pos_in = 32'h0;
  logic [7:0] pattern = 8'h00;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, ref_o, alarm, irq;
  logic [3:0] pc, mc, opc, omc;
  logic [15:0] terms, trusted;
  int miscompares = 0;
  int samples_checked = 0;
  int unsigned seed = 19;
  int cp[4], cm[4], op[4], om[4];
  int hp[6] = '{1050, 950, 850, 1450, 1550, 1650};
  logic [7:0] en = 8'h00;
  logic [3:0] mp = 4'h0;
  logic [3:0] mm = 4'h0;
  bit sync, rot, refd, alm;
  int rng = 360000;
  int ctol = 0;

  always #2.5 clock = ~clock;

  scpm_top #(.cycle_count(cc)) scpm_top_i (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .safe_position(pos_in), .other_plus_cam(opc),
    .other_minus_cam(omc), .plus_cam(pc), .minus_cam(mc), .safe_output_signal(terms),
    .axis_referenced(ref_o), .config_alarm(alarm), .irq(irq));
  scpm_other_channel scpm_other_channel_i (.clock(clock), .reset_n(reset_n),
    .pattern(pattern), .safe_output_signal(terms), .axis_referenced(ref_o),
    .other_plus_cam(opc), .other_minus_cam(omc), .trusted_terms(trusted));

  // ----------------------------------------
  // helpers and reference model
  // ----------------------------------------
  function automatic int unsigned xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // hysteresis state is the model's last output, matching the design's held cam
  function automatic void model(input int p);
    int x;
    logic a;
    logic b;
    x = p;
    if (rot && x >= rng) x = x - rng;
    for (int i = 0; i < 4; i++) begin
      a = (x > cp[i]) || (sync && mp[i] && x > cp[i] - ctol);
      b = (x < cm[i]) || (sync && mm[i] && x < cm[i] + ctol);
      if (sync) begin
        a = a & pattern[i];
        b = b & pattern[4+i];
      end
      mp[i] = a & en[2*i+1];
      mm[i] = b & en[2*i];
    end
  endfunction

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pins(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    if (n >= 40) miscompares++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    wb(1'b0, a, 32'h0);
    cmp_word(q & m, exp);
  endtask

  task automatic set_en();
    wr(`SCPM_OFS_ENABLE, {16'h0, en, sync, 7'h0});
  endtask

  // two full monitoring ticks pass, so the outputs have settled on p
  task automatic look(input int p);
    logic [15:0] t;
    pos_in <= p;
    repeat (2 * cc + 4) @(posedge clock);
    model(p);
    t = 16'h0;
    for (int i = 0; i < 4; i++) begin
      if (op[i] < 16) t[op[i]] = t[op[i]] | mp[i];
      if (om[i] < 16) t[om[i]] = t[om[i]] | mm[i];
    end
    cmp_pins({8'h0, mc, pc}, {8'h0, mm, mp});
    cmp_pins(terms, t);
    cmp_pins(trusted, refd ? t : 16'h0);
    cmp_pins({14'h0, alarm, ref_o}, {14'h0, alm, refd});
  endtask

  task automatic runup();
    wr(`SCPM_OFS_CONTROL, 32'h7);
    repeat (30) @(posedge clock);
    cmp_pins({15'h0, alarm}, {15'h0, alm});
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    end_of_test();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 4; i++) begin
      cp[i] = 1000 * (i + 1);
      cm[i] = 1000 * (i + 1) + 500;
      op[i] = 2 * i;
      om[i] = 2 * i + 1;
    end
    cm[0] = 10;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    rd(`SCPM_OFS_ENABLE, 32'h0, 32'hFFFF_FFFF);
    rd(`SCPM_OFS_MOD_RANGE, 32'h0005_7E40, 32'hFFFF_FFFF);
    rd(8'h30, 32'h0, 32'hFFFF_FFFF);
    rd(`SCPM_OFS_IRQ_CLEAR, 32'h0, 32'hFFFF_FFFF);
    look(2200);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(8'(`SCPM_OFS_CAM_PLUS + 4 * i), cp[i]);
      wr(8'(`SCPM_OFS_CAM_MINUS + 4 * i), cm[i]);
    end
    for (int k = 0; k < 8; k++) begin
      en = 8'h01 << k;
      set_en();
      look(2200);
    end
    $display("test enables done");
    for (int k = 0; k < 12; k++) begin
      en = 8'(xs());
      set_en();
      look(int'(xs() % 6000));
      rd(`SCPM_OFS_STATUS, {22'h0, alm, refd, mm, mp}, 32'h3FF);
    end
    $display("test random positions done");
    en = 8'hFF;
    set_en();
    op[0] = 12;
    om[1] = 16;
    wr(`SCPM_OFS_OUT_PLUS, 32'd12);
    wr(8'(`SCPM_OFS_OUT_MINUS + 4), 32'd16);
    look(1200);
    refd = 1;
    wr(`SCPM_OFS_CONTROL, 32'h4);
    look(3200);
    $display("test routing done");
    ctol = 100;
    wr(`SCPM_OFS_CAM_TOLERANCE, 32'd100);
    sync = 1;
    set_en();
    for (int k = 0; k < 6; k++) begin
      pattern <= 8'(xs());
      look(k * 1000 + 200);
    end
    pattern <= 8'hFF;
    foreach (hp[k]) look(hp[k]);
    sync = 0;
    set_en();
    look(950);
    $display("test sync done");
    rot = 1;
    wr(`SCPM_OFS_CONTROL, 32'h5);
    look(360500);
    look(363700);
    $display("test rotary done");
    wr(`SCPM_OFS_POSITION_TOLERANCE, 32'd10);
    runup();
    cp[3] = 359889;
    wr(8'(`SCPM_OFS_CAM_PLUS + 12), cp[3]);
    runup();
    sync = 1;
    set_en();
    runup();
    cp[3] = 359890;
    wr(8'(`SCPM_OFS_CAM_PLUS + 12), cp[3]);
    alm = 1;
    runup();
    en = 8'h7F;
    alm = 0;
    set_en();
    runup();
    en = 8'hFF;
    alm = 1;
    set_en();
    runup();
    $display("test run-up done");
    rd(`SCPM_OFS_IRQ_STATUS, 32'h1, 32'h1);
    wr(`SCPM_OFS_IRQ_ENABLE, 32'h1);
    repeat (3) @(posedge clock);
    cmp_pins({15'h0, irq}, 16'h1);
    wr(`SCPM_OFS_IRQ_ENABLE, 32'h0);
    repeat (3) @(posedge clock);
    cmp_pins({15'h0, irq}, 16'h0);
    wr(`SCPM_OFS_IRQ_CLEAR, 32'h3);
    rd(`SCPM_OFS_IRQ_STATUS, 32'h0, 32'h3);
    wr(`SCPM_OFS_IRQ_ENABLE, 32'h3);
    look(360500);
    cmp_pins({15'h0, irq}, 16'h1);
    $display("test interrupts done");
    end_of_test();
  end
endmodule
